// file: core/acs_pkg.sv
package acs_pkg;

  // Result width
  localparam int RESULT_W = 12;

  // Clock rate and timing
  localparam int CLK_PERIOD_NS     = 10;
  localparam int START_MIN_NS      = 10;
  localparam int START_MIN_CYC     = (START_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CYC_DEFAULT  = 88;
  localparam int TRACK_LEAD_CYC    = 1;
  localparam int WAKE_PARTIAL_CYC  = 4;
  localparam int WAKE_FULL_CYC     = 40;
  localparam int CNT_W             = 16;

  // Values after reset
  localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000;

  // Converter sequencing states
  typedef enum logic [4:0] {
    ACS_ACQUIRE = 5'h01,
    ACS_CONVERT = 5'h02,
    ACS_SLEEP   = 5'h04,
    ACS_WAKE    = 5'h08,
    ACS_IDLE_HI = 5'h10
  } acs_state_t;

  // Power controls toward the analog section
  typedef struct packed {
    logic ref_on;
    logic osc_on;
    logic analog_on;
  } acs_power_t;

endpackage : acs_pkg

// file: core/acs_sync.sv
`timescale 1ns/1ps
// Three-stage synchroniser; change accepted when stages two and three agree
module acs_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic din,
  output logic      dout,
  output logic      fall,
  output logic      rise
);

  logic [2:0] stage;
  logic [2:0] next_stage;
  logic       next_dout;

  // Stage one feeds only stage two
  always_comb begin
    next_stage = {stage[1], stage[0], din};
    next_dout  = dout;
    if (stage[2] == stage[1]) begin
      next_dout = stage[2];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stage <= {3{RST_VAL}};
      dout  <= RST_VAL;
    end else begin
      stage <= next_stage;
      dout  <= next_dout;
    end
  end

  // Edges from stages two and three, so a single-sample pulse still counts
  assign fall = stage[2] & ~stage[1];
  assign rise = ~stage[2] & stage[1];

endmodule : acs_sync

// file: core/acs_ctrl.sv
`timescale 1ns/1ps
// Functional notes
// - Result bus is driven only while chip select and read are both low, as one AND.
// - With both strobes held low the bus stays driven and a new result shows on the same edge that busy falls.
// - A start falling edge puts the track/hold into hold and starts a conversion.
// - A start low pulse of ten nanoseconds is a valid trigger.
// - Start still low at the end of conversion enters the selected sleep depth.
// - In sleep the next start rising edge wakes the part, wake time set by depth.
// - Partial sleep keeps reference and oscillator on, full sleep powers all analog down.
// - Busy rises after the start falling edge and stays high for the whole conversion.
// - Busy falls on the same clock edge that loads the result into the output register.
// - Track/hold returns to track just before busy falls; acquisition starts with busy low.
// - Start low as busy falls means sleep is entered on that busy falling edge.
// - A start falling edge while busy aborts and restarts conversion from the new sample.
// - The result port is twelve bits, three-stated whenever either strobe is high.
module acs_ctrl #(
  parameter int CONV_CYC = acs_pkg::CONV_CYC_DEFAULT
) (
  input  wire logic                         ref_clk,
  input  wire logic                         rst,
  input  wire logic                         conversion_start_n,
  input  wire logic                         sleep_depth_select,
  input  wire logic                         chip_select_n,
  input  wire logic                         read_n,
  input  wire logic [acs_pkg::RESULT_W-1:0] sar_value,
  output logic      [acs_pkg::RESULT_W-1:0] result_bus,
  output logic      [acs_pkg::RESULT_W-1:0] result_bus_oe,
  output logic                              busy,
  output logic                              hold,
  output logic                              sleeping,
  output acs_pkg::acs_power_t               power
);

  localparam logic [acs_pkg::CNT_W-1:0] CONV_LAST  = acs_pkg::CNT_W'(CONV_CYC - 1);
  localparam logic [acs_pkg::CNT_W-1:0] TRACK_AT   =
    acs_pkg::CNT_W'(CONV_CYC - 1 - acs_pkg::TRACK_LEAD_CYC);
  localparam logic [acs_pkg::CNT_W-1:0] WAKE_P_LAST =
    acs_pkg::CNT_W'(acs_pkg::WAKE_PARTIAL_CYC - 1);
  localparam logic [acs_pkg::CNT_W-1:0] WAKE_F_LAST =
    acs_pkg::CNT_W'(acs_pkg::WAKE_FULL_CYC - 1);

  logic start_lvl;
  logic start_fall;
  logic start_rise;
  logic sel_lvl;
  logic cs_lvl;
  logic rd_lvl;

  // Start pin; edges skip the agreement filter so a one-cycle 10 ns pulse is caught
  acs_sync #(.RST_VAL(1'b1)) u_sync_start (
    .ref_clk (ref_clk),
    .rst     (rst),
    .din     (conversion_start_n),
    .dout    (start_lvl),
    .fall    (start_fall),
    .rise    (start_rise)
  );

  acs_sync #(.RST_VAL(1'b1)) u_sync_sel (
    .ref_clk (ref_clk),
    .rst     (rst),
    .din     (sleep_depth_select),
    .dout    (sel_lvl),
    .fall    (),
    .rise    ()
  );

  acs_sync #(.RST_VAL(1'b1)) u_sync_cs (
    .ref_clk (ref_clk),
    .rst     (rst),
    .din     (chip_select_n),
    .dout    (cs_lvl),
    .fall    (),
    .rise    ()
  );

  acs_sync #(.RST_VAL(1'b1)) u_sync_rd (
    .ref_clk (ref_clk),
    .rst     (rst),
    .din     (read_n),
    .dout    (rd_lvl),
    .fall    (),
    .rise    ()
  );

  acs_pkg::acs_state_t                state;
  acs_pkg::acs_state_t                next_state;
  logic [acs_pkg::CNT_W-1:0]          cnt;
  logic [acs_pkg::CNT_W-1:0]          next_cnt;
  logic [acs_pkg::RESULT_W-1:0]       result_reg;
  logic [acs_pkg::RESULT_W-1:0]       next_result_reg;
  logic                               next_busy;
  logic                               next_hold;
  logic                               next_sleeping;
  logic                               deep;
  logic                               next_deep;
  acs_pkg::acs_power_t                next_power;
  logic [acs_pkg::RESULT_W-1:0]       next_result_bus;
  logic [acs_pkg::RESULT_W-1:0]       next_result_bus_oe;
  logic                               read_on;

  // Conversion, sleep and wake sequencing
  always_comb begin
    next_state      = state;
    next_cnt        = cnt;
    next_result_reg = result_reg;
    next_busy       = busy;
    next_hold       = hold;
    next_sleeping   = sleeping;
    next_deep       = deep;
    case (state)
      acs_pkg::ACS_ACQUIRE, acs_pkg::ACS_IDLE_HI: begin
        if (start_fall) begin
          next_state = acs_pkg::ACS_CONVERT;
          next_hold  = 1'b1;
          next_busy  = 1'b1;
          next_cnt   = '0;
        end
      end
      acs_pkg::ACS_CONVERT: begin
        if (start_fall) begin
          // Restart from the fresh sample, busy stays high
          next_cnt  = '0;
          next_hold = 1'b1;
        end else if (cnt == CONV_LAST) begin
          // Result latched on the same edge that busy drops
          next_result_reg = sar_value;
          next_busy       = 1'b0;
          next_hold       = 1'b0;
          if (!start_lvl) begin
            next_state    = acs_pkg::ACS_SLEEP;
            next_sleeping = 1'b1;
            next_deep     = ~sel_lvl;
          end else begin
            next_state = acs_pkg::ACS_ACQUIRE;
          end
        end else begin
          next_cnt = cnt + 1'b1;
          if (cnt == TRACK_AT) begin
            next_hold = 1'b0;
          end
        end
      end
      acs_pkg::ACS_SLEEP: begin
        if (start_rise) begin
          next_state = acs_pkg::ACS_WAKE;
          next_cnt   = '0;
        end
      end
      acs_pkg::ACS_WAKE: begin
        // Wake time depends on how deep the sleep was
        if (cnt == (deep ? WAKE_F_LAST : WAKE_P_LAST)) begin
          next_state    = acs_pkg::ACS_IDLE_HI;
          next_sleeping = 1'b0;
          next_deep     = 1'b0;
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
      default: begin
        next_state    = acs_pkg::ACS_ACQUIRE;
        next_busy     = 1'b0;
        next_hold     = 1'b0;
        next_sleeping = 1'b0;
        next_deep     = 1'b0;
        next_cnt      = '0;
      end
    endcase
  end

  // Power-domain controls follow the sleep depth
  always_comb begin
    next_power.ref_on    = 1'b1;
    next_power.osc_on    = 1'b1;
    next_power.analog_on = 1'b1;
    if (next_sleeping) begin
      next_power.analog_on = 1'b0;
      next_power.ref_on    = ~next_deep;
      next_power.osc_on    = ~next_deep;
    end
  end

  // Read port; strobes are one AND, so either order works
  assign read_on = ~cs_lvl & ~rd_lvl;

  always_comb begin
    next_result_bus    = result_bus;
    next_result_bus_oe = {acs_pkg::RESULT_W{read_on}};
    if (read_on) begin
      // Tracks the register, so a held-low read shows each new result as busy drops
      next_result_bus = next_result_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state         <= acs_pkg::ACS_ACQUIRE;
      cnt           <= '0;
      result_reg    <= acs_pkg::RESULT_RST;
      busy          <= 1'b0;
      hold          <= 1'b0;
      sleeping      <= 1'b0;
      deep          <= 1'b0;
      power         <= '1;
      result_bus    <= acs_pkg::RESULT_RST;
      result_bus_oe <= '0;
    end else begin
      state         <= next_state;
      cnt           <= next_cnt;
      result_reg    <= next_result_reg;
      busy          <= next_busy;
      hold          <= next_hold;
      sleeping      <= next_sleeping;
      deep          <= next_deep;
      power         <= next_power;
      result_bus    <= next_result_bus;
      result_bus_oe <= next_result_bus_oe;
    end
  end

endmodule : acs_ctrl

// file: verification/acs_ctrl_props.sv
`timescale 1ns/1ps
module acs_ctrl_props #(
  parameter int CONV_CYC = acs_pkg::CONV_CYC_DEFAULT
) (
  input wire logic                         ref_clk,
  input wire logic                         rst,
  input wire logic                         conversion_start_n,
  input wire logic                         sleep_depth_select,
  input wire logic                         chip_select_n,
  input wire logic                         read_n,
  input wire logic [acs_pkg::RESULT_W-1:0] result_bus_oe,
  input wire logic                         busy,
  input wire logic                         hold,
  input wire logic                         sleeping,
  input wire acs_pkg::acs_power_t          power
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [15:0] blen;
  logic [15:0] next_blen;
  // Busy run length; restarts make it longer, never shorter
  always_comb next_blen = busy ? blen + 16'h0001 : 16'h0000;
  always_ff @(posedge ref_clk) blen <= rst ? 16'h0000 : next_blen;
  AST_OE_OFF: assert property ((chip_select_n || read_n) [*6]
    |-> result_bus_oe == 12'h000)
    else $error("result bus driven with a strobe high");
  AST_OE_ON: assert property ((!chip_select_n && !read_n) [*6]
    |-> result_bus_oe == 12'hFFF)
    else $error("result bus not driven with both strobes low");
  AST_BUSY_LEN: assert property ($fell(busy) |-> blen >= CONV_CYC)
    else $error("busy shorter than a conversion");
  AST_HOLD_START: assert property ($rose(busy) |-> hold)
    else $error("hold not taken with busy");
  AST_TRACK_LEAD: assert property ($fell(busy) |-> !$past(hold) && $past(hold, 2))
    else $error("track not resumed one cycle before busy fell");
  AST_SLEEP_AT_FALL: assert property ($rose(sleeping) |-> $fell(busy))
    else $error("sleep entered away from busy fall");
  AST_SLEEP_ENTER: assert property ($fell(busy) && !conversion_start_n
    && !$past(conversion_start_n, 6) |-> sleeping)
    else $error("no sleep with start held low");
  AST_DEPTH: assert property ($rose(sleeping)
    |-> power == (sleep_depth_select ? 3'h6 : 3'h0))
    else $error("wrong sleep power");
  AST_WAKE: assert property ($fell(sleeping) |-> conversion_start_n && power == 3'h7)
    else $error("wake without start high or power");
  COV_CONV: cover property ($fell(busy));
  COV_SLEEP: cover property ($rose(sleeping));
  COV_READ: cover property (result_bus_oe == 12'hFFF);
endmodule : acs_ctrl_props

// file: verification/acs_host.sv
`timescale 1ns/1ps
module acs_host (
  input  wire logic        ref_clk,
  input  wire logic        busy,
  input  wire logic        sleeping,
  input  wire logic [11:0] result_bus,
  output logic             conversion_start_n,
  output logic             chip_select_n,
  output logic             read_n
);
  int fails = 0;
  initial {conversion_start_n, chip_select_n, read_n} = 3'h7;
  // Start pulse of width cycles (0 holds it low), optional restart, busy counted throughout
  task conv(input int gap, input int width, output int len, output logic [11:0] d);
    int i;
    len = 0;
    d   = result_bus;
    @(negedge ref_clk) conversion_start_n = 1'b0;
    for (i = 1; i < 400 && !(len > 0 && busy === 1'b0); i++) begin
      @(negedge ref_clk);
      if (busy === 1'b1) len++;
      d = result_bus;
      if (i == width) conversion_start_n = 1'b1;
      if (gap > 0 && i == gap) conversion_start_n = 1'b0;
      if (gap > 0 && i == gap + 2) conversion_start_n = 1'b1;
    end
    if (i == 400) fails++;
    repeat (14) @(negedge ref_clk); // Acquisition gap
  endtask : conv
  // Reads only between conversions
  task rd(output logic [11:0] d);
    @(negedge ref_clk) {chip_select_n, read_n} = 2'h0;
    repeat (6) @(negedge ref_clk);
    d = result_bus;
    {chip_select_n, read_n} = 2'h3;
    repeat (6) @(negedge ref_clk);
  endtask : rd
  task strobes(input bit v);
    @(negedge ref_clk) {chip_select_n, read_n} = {v, v};
    repeat (6) @(negedge ref_clk);
  endtask : strobes
  task wake(output int w);
    @(negedge ref_clk) conversion_start_n = 1'b1;
    for (w = 0; sleeping !== 1'b0 && w < 100; w++) @(negedge ref_clk);
    if (w == 100) fails++;
    repeat (14) @(negedge ref_clk);
  endtask : wake
endmodule : acs_host

// file: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam int CONV_CYC = 10;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic sleep_depth_select = 1'b1;
  logic [11:0] sar_value = 12'h000;
  logic conversion_start_n, chip_select_n, read_n, busy, hold, sleeping;
  logic [11:0] result_bus, result_bus_oe;
  acs_pkg::acs_power_t power;
  int num_errors = 0;
  int num_checks = 0;
  int wp, wf;
  always #5 ref_clk = ~ref_clk;
  acs_ctrl #(.CONV_CYC(CONV_CYC)) dut_u (.ref_clk(ref_clk), .rst(rst),
    .conversion_start_n(conversion_start_n), .sleep_depth_select(sleep_depth_select),
    .chip_select_n(chip_select_n), .read_n(read_n), .sar_value(sar_value),
    .result_bus(result_bus), .result_bus_oe(result_bus_oe), .busy(busy), .hold(hold),
    .sleeping(sleeping), .power(power));
  acs_host host_u (.ref_clk(ref_clk), .busy(busy), .sleeping(sleeping),
    .result_bus(result_bus), .conversion_start_n(conversion_start_n),
    .chip_select_n(chip_select_n), .read_n(read_n));
  task chk(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task give_verdict;
    if (num_errors == 0 && host_u.fails == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  // Single conversion, then a strobed read
  task s_single;
    int len;
    logic [11:0] d;
    sar_value = 12'hA5C;
    host_u.conv(0, 2, len, d);
    chk(12'(len), 12'(CONV_CYC));
    host_u.rd(d);
    chk(d, 12'hA5C);
    chk(result_bus_oe, 12'h000);
  endtask : s_single
  // One-cycle start pulse must still run a full conversion
  task s_short;
    int len;
    logic [11:0] d;
    sar_value = 12'h1F0;
    host_u.conv(0, 1, len, d);
    chk(12'(len), 12'(CONV_CYC));
    host_u.rd(d);
    chk(d, 12'h1F0);
  endtask : s_short
  // Second start edge during busy stretches busy by the gap
  task s_restart;
    int len;
    logic [11:0] d;
    sar_value = 12'h3C1;
    host_u.conv(6, 2, len, d);
    chk(12'(len), 12'(CONV_CYC + 6));
  endtask : s_restart
  // Strobes tied low: new result visible as busy falls
  task s_stream;
    int len;
    logic [11:0] d;
    host_u.strobes(1'b0);
    sar_value = 12'h7E2;
    host_u.conv(0, 2, len, d);
    chk(d, 12'h7E2);
    chk(result_bus_oe, 12'hFFF);
    host_u.strobes(1'b1);
  endtask : s_stream
  task s_sleep(input logic sel, output int w);
    int len;
    logic [11:0] d;
    sleep_depth_select = sel;
    host_u.conv(0, 0, len, d);
    chk({11'h000, sleeping}, 12'h001);
    chk({9'h000, power}, sel ? 12'h006 : 12'h000);
    host_u.wake(w);
    chk({9'h000, power}, 12'h007);
  endtask : s_sleep
  initial begin
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    s_single();
    s_short();
    s_restart();
    s_stream();
    s_sleep(1'b1, wp);
    s_sleep(1'b0, wf);
    chk(12'(wf - wp), 12'(acs_pkg::WAKE_FULL_CYC - acs_pkg::WAKE_PARTIAL_CYC));
    give_verdict();
  end
endmodule : tb_top
bind acs_ctrl acs_ctrl_props #(.CONV_CYC(CONV_CYC)) props_u (.ref_clk(ref_clk), .rst(rst),
  .conversion_start_n(conversion_start_n), .sleep_depth_select(sleep_depth_select),
  .chip_select_n(chip_select_n), .read_n(read_n), .result_bus_oe(result_bus_oe),
  .busy(busy), .hold(hold), .sleeping(sleeping), .power(power));
